// file: shared/dcf_pkg.sv
// Purpose: Constants for the debug control field logic
// Assumes: Avalon-MM slave with 32-bit data, byte addresses
// Notes: Control word holds bits 19 down to 11 of the debug configuration word
package dcf_pkg;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STAT_OFFSET = 4'h4;
  localparam logic [3:0] HOSTCTRL_OFFSET = 4'h8;
  localparam int RSVD_POS = 19;
  localparam int BKMODE_POS = 18;
  localparam int TPDIS_POS = 17;
  localparam int WINH_POS = 16;
  localparam int MAP_POS = 15;
  localparam int TRCEMU_POS = 14;
  localparam int FORCEEMU_POS = 13;
  localparam int CAPSEL_POS = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] TT_EMU = 2'h2;
  localparam logic [2:0] TM_EMU_CODE = 3'h5;
  localparam logic [2:0] TM_EMU_DATA = 3'h6;
  localparam logic [1:0] CAP_NONE = 2'h0;
  localparam logic [1:0] CAP_WRITE = 2'h1;
  localparam logic [1:0] CAP_READ = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;
  localparam logic [3:0] TRACE_IDLE_STATUS = 4'h0;
  localparam int CLOCK_MHZ = 250;
  localparam int BYTE_NIBBLES = 2;
  localparam int LONG_NIBBLES = 8;
  localparam int WORD_NIBBLES = 4;
endpackage : dcf_pkg

// file: core/dcf_debug_ctrl.sv
// Purpose: Debug control field bits 19..11 and the logic they steer
// Assumes: Breakpoint pin is asynchronous; core signals share I_CLOCK
// Notes: Status register reads inhibit bit, pending, handler and streaming state
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - mode clear: pin keeps normal function
// - mode set: falling pin edge raises interrupt
// - interrupt pending until instruction sample point
// - no nested debug interrupts
// - trace disable quiets clock, status, data
// - inhibit blocks core writes to registers
// - only external system changes inhibit bit
// - map clear: supervisor code/data spaces
// - map set in emulator mode: special space TT 10, TM 101/110
// - trace exception enters emulator mode if set
// - force bit starts emulator mode execution
// - capture field picks none/write/read/both data
// - operand sent one nibble per clock by size
module dcf_debug_ctrl (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Avalon-MM slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic I_AVS_FROM_HOST,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Breakpoint pin and core handshake
  input wire logic I_BREAKPOINT_REQUEST_PIN_N,
  input wire logic I_SAMPLE_POINT,
  input wire logic I_DEBUG_DONE,
  input wire logic I_TRACE_EXCEPTION,
  input wire logic I_EMU_MODE,
  input wire logic I_REF_IS_CODE,
  output logic O_DEBUG_IRQ,
  output logic O_BREAKPOINT_HALT,
  output logic O_ENTER_EMULATOR,
  output logic O_CORE_WRITE_INHIBIT,
  output logic [1:0] O_TRANSFER_TYPE,
  output logic [2:0] O_TRANSFER_MODIFIER,
  output logic O_USE_SPECIAL_SPACE,
  // Operand capture input
  input wire logic I_OPER_VALID,
  input wire logic I_OPER_IS_WRITE,
  input wire logic [1:0] I_OPER_SIZE,
  input wire logic [31:0] I_OPER_DATA,
  output logic O_OPER_READY,
  // Trace port
  input wire logic [3:0] I_CORE_STATUS,
  output logic O_TRACE_CLOCK_OUT,
  output logic [3:0] O_PROCESSOR_STATUS_OUTPUTS,
  output logic [3:0] O_DEBUG_DATA_OUTPUTS
);

  typedef enum logic [1:0] {IDLE, ACK, SHIFT} dcf_bus_type;

  typedef struct packed {
    logic [8:0] ctrl;
    logic host_access;
    dcf_bus_type bus;
    logic [31:0] rdata;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic pending;
    logic in_handler;
    logic irq;
    logic [31:0] shreg;
    logic [3:0] nib_left;
    logic tclk;
    logic [3:0] processor_status_outputs;
    logic [3:0] dd;
  } dcf_state_type;

  dcf_state_type st;
  dcf_state_type next_st;

  function automatic logic [3:0] dcf_nibbles(input logic [1:0] size);
    case (size)
      2'h1: dcf_nibbles = 4'(dcf_pkg::BYTE_NIBBLES);
      2'h2: dcf_nibbles = 4'(dcf_pkg::WORD_NIBBLES);
      default: dcf_nibbles = 4'(dcf_pkg::LONG_NIBBLES);
    endcase
  endfunction : dcf_nibbles

  function automatic logic dcf_bit(input logic [8:0] c, input int pos);
    dcf_bit = c[pos - dcf_pkg::CAPSEL_POS];
  endfunction : dcf_bit

  logic bk_mode;
  logic tp_dis;
  logic winh;
  logic map_sp;
  logic [1:0] capsel;
  logic oper_take;
  logic capture_hit;
  logic [8:0] wr_field;
  logic [31:0] ctrl_word;

  always_comb begin
    bk_mode = dcf_bit(st.ctrl, dcf_pkg::BKMODE_POS);
    tp_dis = dcf_bit(st.ctrl, dcf_pkg::TPDIS_POS);
    winh = dcf_bit(st.ctrl, dcf_pkg::WINH_POS);
    map_sp = dcf_bit(st.ctrl, dcf_pkg::MAP_POS);
    capsel = st.ctrl[1:0];
    ctrl_word = 32'(st.ctrl) << dcf_pkg::CAPSEL_POS;
    wr_field = I_AVS_WRITEDATA[dcf_pkg::RSVD_POS:dcf_pkg::CAPSEL_POS];
    capture_hit = (I_OPER_IS_WRITE && capsel[0]) || (!I_OPER_IS_WRITE && capsel[1]);
    oper_take = I_OPER_VALID && (st.nib_left == 4'h0);
  end

  always_comb begin
    next_st = st;
    // Bus slave: one wait cycle, answer on second edge
    case (st.bus)
      IDLE: begin
        if (I_AVS_READ || I_AVS_WRITE) begin
          next_st.bus = ACK;
          next_st.host_access = I_AVS_FROM_HOST;
          case (I_AVS_ADDRESS)
            dcf_pkg::CTRL_OFFSET: next_st.rdata = ctrl_word;
            dcf_pkg::STAT_OFFSET: next_st.rdata = {28'h0, st.nib_left != 4'h0, st.in_handler,
                                                   st.pending, winh};
            dcf_pkg::HOSTCTRL_OFFSET: next_st.rdata = ctrl_word;
            default: next_st.rdata = 32'h0000_0000;
          endcase
        end
      end
      ACK: begin
        // Write lands on the second edge, the one after the wait cycle
        next_st.bus = IDLE;
        if (I_AVS_WRITE) begin
          if (I_AVS_ADDRESS == dcf_pkg::CTRL_OFFSET && !winh) begin
            next_st.ctrl = wr_field;
            next_st.ctrl[dcf_pkg::WINH_POS - dcf_pkg::CAPSEL_POS] = winh;
            next_st.ctrl[8] = 1'b0;
          end
          if (I_AVS_ADDRESS == dcf_pkg::HOSTCTRL_OFFSET && st.host_access) begin
            next_st.ctrl = wr_field;
            next_st.ctrl[8] = 1'b0;
          end
        end
      end
      default: next_st.bus = IDLE;
    endcase
    // Breakpoint pin: two-flop sync then falling edge detect
    next_st.pin_s1 = I_BREAKPOINT_REQUEST_PIN_N;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.irq = 1'b0;
    if (I_DEBUG_DONE) begin
      next_st.in_handler = 1'b0;
    end
    if (bk_mode && st.pin_prev && !st.pin_s2 && !st.in_handler) begin
      next_st.pending = 1'b1;
    end
    if (st.pending && I_SAMPLE_POINT && !st.in_handler) begin
      next_st.pending = 1'b0;
      next_st.irq = 1'b1;
      next_st.in_handler = 1'b1;
    end
    if (!bk_mode) begin
      next_st.pending = 1'b0;
    end
    // Trace port and operand nibble stream
    if (oper_take && capture_hit) begin
      next_st.shreg = I_OPER_DATA;
      next_st.nib_left = dcf_nibbles(I_OPER_SIZE);
    end else if (st.nib_left != 4'h0) begin
      next_st.shreg = {4'h0, st.shreg[31:4]};
      next_st.nib_left = st.nib_left - 4'h1;
    end
    if (tp_dis) begin
      next_st.tclk = 1'b0;
      next_st.processor_status_outputs = dcf_pkg::TRACE_IDLE_STATUS;
      next_st.dd = 4'h0;
      next_st.nib_left = 4'h0;
    end else begin
      next_st.tclk = !st.tclk;
      next_st.processor_status_outputs = I_CORE_STATUS;
      next_st.dd = (st.nib_left != 4'h0) ? st.shreg[3:0] : 4'h0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= '0;
      st.pin_s1 <= 1'b1;
      st.pin_s2 <= 1'b1;
      st.pin_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    O_AVS_READDATA = st.rdata;
    O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && (st.bus != ACK);
    O_DEBUG_IRQ = st.irq;
    O_BREAKPOINT_HALT = !bk_mode && !st.pin_s2;
    O_ENTER_EMULATOR = dcf_bit(st.ctrl, dcf_pkg::FORCEEMU_POS)
      || (dcf_bit(st.ctrl, dcf_pkg::TRCEMU_POS) && I_TRACE_EXCEPTION);
    O_CORE_WRITE_INHIBIT = winh;
    O_USE_SPECIAL_SPACE = I_EMU_MODE && map_sp;
    if (I_EMU_MODE && map_sp) begin
      O_TRANSFER_TYPE = dcf_pkg::TT_EMU;
      O_TRANSFER_MODIFIER = I_REF_IS_CODE ? dcf_pkg::TM_EMU_CODE : dcf_pkg::TM_EMU_DATA;
    end else begin
      O_TRANSFER_TYPE = 2'h0;
      O_TRANSFER_MODIFIER = I_REF_IS_CODE ? 3'h6 : 3'h5;
    end
    O_OPER_READY = st.nib_left == 4'h0;
    O_TRACE_CLOCK_OUT = st.tclk;
    O_PROCESSOR_STATUS_OUTPUTS = st.processor_status_outputs;
    O_DEBUG_DATA_OUTPUTS = st.dd;
  end

  bus_answer_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.bus == IDLE && I_AVS_READ) |=> !O_AVS_WAITREQUEST)
    else $error("bus answer late");
  edge_pending_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (bk_mode && st.pin_prev && !st.pin_s2 && !st.in_handler && !I_SAMPLE_POINT)
    |=> (st.pending || !bk_mode))
    else $error("falling edge not held pending");
  normal_mode_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !bk_mode |=> !st.pending)
    else $error("pending in normal mode");
  sample_irq_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_DEBUG_IRQ |-> $past(I_SAMPLE_POINT) && $past(st.pending))
    else $error("irq without sample point");
  no_nesting_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.in_handler && !I_DEBUG_DONE) |=> !O_DEBUG_IRQ)
    else $error("nested debug irq");
  trace_quiet_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    tp_dis[*2] |-> !O_TRACE_CLOCK_OUT && O_DEBUG_DATA_OUTPUTS == 4'h0)
    else $error("trace port active while disabled");
  trace_resume_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    ($past(I_RST_N) && !tp_dis && $past(!tp_dis)) |-> O_TRACE_CLOCK_OUT != $past(O_TRACE_CLOCK_OUT))
    else $error("trace clock not running");
  inhibit_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.bus == ACK && I_AVS_WRITE && !st.host_access) |=> $stable(winh))
    else $error("core changed inhibit bit");
  map_space_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_EMU_MODE && map_sp) |-> O_TRANSFER_TYPE == 2'h2)
    else $error("special space not used");
  nibble_count_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (oper_take && capture_hit && !tp_dis && I_OPER_SIZE == 2'h1) |=> st.nib_left == 4'h2)
    else $error("byte not two nibbles");
  write_answer_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.bus == IDLE && I_AVS_WRITE) |=> !O_AVS_WAITREQUEST)
    else $error("bus write answer late");
  core_block_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.bus == ACK && I_AVS_WRITE && winh && I_AVS_ADDRESS == dcf_pkg::CTRL_OFFSET)
    |=> $stable(st.ctrl))
    else $error("core write passed inhibit");
  rsvd_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    st.ctrl[8] == 1'b0)
    else $error("reserved bit set");
  halt_normal_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    bk_mode |-> !O_BREAKPOINT_HALT)
    else $error("halt in debug interrupt mode");
  irq_pulse_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_DEBUG_IRQ |=> !O_DEBUG_IRQ)
    else $error("debug irq longer than one cycle");
  irq_handler_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_DEBUG_IRQ |-> st.in_handler)
    else $error("irq without handler mark");
  trace_status_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    tp_dis[*2] |-> O_PROCESSOR_STATUS_OUTPUTS == dcf_pkg::TRACE_IDLE_STATUS)
    else $error("status outputs active while disabled");
  nibble_step_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.nib_left != 4'h0 && !tp_dis) |=> st.nib_left == $past(st.nib_left) - 4'h1)
    else $error("nibble count not stepping");
  nibble_out_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.nib_left != 4'h0 && !tp_dis) |=> O_DEBUG_DATA_OUTPUTS == $past(st.shreg[3:0]))
    else $error("wrong nibble on data outputs");
  no_capture_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (oper_take && capsel == dcf_pkg::CAP_NONE) |=> st.nib_left == 4'h0)
    else $error("operand captured with capture off");
  long_count_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (oper_take && capture_hit && !tp_dis && I_OPER_SIZE[1] == I_OPER_SIZE[0])
    |=> st.nib_left == 4'h8)
    else $error("long not eight nibbles");
  super_space_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !(I_EMU_MODE && map_sp) |-> !O_USE_SPECIAL_SPACE && O_TRANSFER_TYPE != dcf_pkg::TT_EMU)
    else $error("special space outside mapping");
  map_modifier_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_EMU_MODE && map_sp)
    |-> O_TRANSFER_MODIFIER == (I_REF_IS_CODE ? dcf_pkg::TM_EMU_CODE : dcf_pkg::TM_EMU_DATA))
    else $error("special space modifier wrong");
  pending_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (st.pending && bk_mode && !I_SAMPLE_POINT) |=> st.pending)
    else $error("pending interrupt lost");

  irq_seen_c: cover property (@(posedge I_CLOCK) O_DEBUG_IRQ);
  stream_c: cover property (@(posedge I_CLOCK) st.nib_left == 4'h8);
  host_wr_c: cover property (@(posedge I_CLOCK) I_AVS_WRITE && I_AVS_FROM_HOST && !O_AVS_WAITREQUEST);
  trace_off_c: cover property (@(posedge I_CLOCK) tp_dis && !O_TRACE_CLOCK_OUT);
  inhibit_c: cover property (@(posedge I_CLOCK) O_CORE_WRITE_INHIBIT);

endmodule : dcf_debug_ctrl

`default_nettype wire

// file: test/dcf_host_model.sv
// Purpose: Development system side: breakpoint pin and trace watch
// Assumes: Pin has a pull-up and idles high
// Notes: A pulse on i_fall holds the pin low for six cycles
`timescale 1ns/1ns
`default_nettype none
module dcf_host_model (
  // Clock and command
  input wire logic i_clk,
  input wire logic i_fall,
  input wire logic i_trace_clk,
  // Pin and trace count
  output logic o_pin_n,
  output int o_toggles
);
  int low = 0;
  int count = 0;
  logic last = 1'b0;
  assign o_toggles = count;
  assign o_pin_n = (low == 0);
  always @(posedge i_clk) begin
    if (i_fall) low <= 6;
    else if (low > 0) low <= low - 1;
    if (i_trace_clk !== last) count <= count + 1;
    last <= i_trace_clk;
  end
endmodule : dcf_host_model
`default_nettype wire

// file: test/debug_control_field_logic_tb_top.sv
// Purpose: Bus, pin, trace and capture tests of the control field
// Assumes: Slave answers each access within the bus wait bound
// Notes: Host control write sets the inhibit bit
`timescale 1ns/1ns
`default_nettype none
module debug_control_field_logic_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, host = 1'b0;
  logic fall = 1'b0, sp = 1'b0, done = 1'b0, trace_exception_emulate = 1'b0, force_emulator_entry = 1'b0, code = 1'b0;
  logic ov = 1'b0, ow = 1'b0, wreq, irq, halt, ent, inh, spc, ordy, tclk, pin_n;
  logic [1:0] osz = 2'h0, tt;
  logic [2:0] tm;
  logic [3:0] adr = 4'h0, processor_status_outputs, dd;
  logic [31:0] wd = 32'h0, rdq, q;
  int tog, t, n_mismatch = 0, compares = 0;
  always #2 clk = ~clk;
  dcf_debug_ctrl i_dcf_debug_ctrl (.I_CLOCK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_FROM_HOST(host),
    .O_AVS_READDATA(rdq), .O_AVS_WAITREQUEST(wreq), .I_BREAKPOINT_REQUEST_PIN_N(pin_n),
    .I_SAMPLE_POINT(sp), .I_DEBUG_DONE(done), .I_TRACE_EXCEPTION(trace_exception_emulate), .I_EMU_MODE(force_emulator_entry),
    .I_REF_IS_CODE(code), .O_DEBUG_IRQ(irq), .O_BREAKPOINT_HALT(halt),
    .O_ENTER_EMULATOR(ent), .O_CORE_WRITE_INHIBIT(inh), .O_TRANSFER_TYPE(tt),
    .O_TRANSFER_MODIFIER(tm), .O_USE_SPECIAL_SPACE(spc), .I_OPER_VALID(ov),
    .I_OPER_IS_WRITE(ow), .I_OPER_SIZE(osz), .I_OPER_DATA(32'h8765_4321),
    .O_OPER_READY(ordy), .I_CORE_STATUS(4'h5), .O_TRACE_CLOCK_OUT(tclk),
    .O_PROCESSOR_STATUS_OUTPUTS(processor_status_outputs), .O_DEBUG_DATA_OUTPUTS(dd));
  dcf_host_model i_dcf_host_model (.i_clk(clk), .i_fall(fall), .i_trace_clk(tclk),
    .o_pin_n(pin_n), .o_toggles(tog));
  task results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task bus(input logic w, input logic h, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {rd, wr, host, adr, wd} <= {!w, w, h, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdq;
    {rd, wr} <= 2'b00;
    if (wreq !== 1'b0) begin
      n_mismatch++;
      results();
    end
    @(posedge clk);
  endtask : bus
  task wc(input logic [31:0] d);
    bus(1'b1, 1'b0, dcf_pkg::CTRL_OFFSET, d);
  endtask : wc
  task pin;
    @(posedge clk);
    fall <= 1'b1;
    @(posedge clk);
    fall <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pin
  task irqs(input int e);
    int c;
    c = 0;
    @(posedge clk);
    sp <= 1'b1;
    @(posedge clk);
    sp <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (irq === 1'b1) c++;
    end
    chk("debug irq", e, c);
  endtask : irqs
  task op(input logic w, input logic [1:0] s, input int e);
    int c;
    int k;
    logic b;
    logic [31:0] v;
    c = 0;
    k = 0;
    b = 1'b0;
    v = 32'h0000_0000;
    @(posedge clk);
    {ov, ow, osz} <= {1'b1, w, s};
    @(posedge clk);
    ov <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (b && k < 8) begin
        v[4 * k +: 4] = dd;
        k++;
      end
      b = (ordy === 1'b0);
      if (ordy === 1'b0) c++;
    end
    chk("stream cycles", e, c);
    chk("stream data", 32'h8765_4321 & ~(32'hFFFF_FFFF << (4 * e)), v);
  endtask : op
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 1'b0, dcf_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl reset", dcf_pkg::CTRL_RESET, q);
    wc(32'h0007_F800);
    bus(1'b0, 1'b0, dcf_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl bits", 32'h0006_F800, q);
    chk("force emu", 1, ent);
    t = tog;
    repeat (8) @(posedge clk);
    chk("trace off", 0, tog - t);
    chk("status off", dcf_pkg::TRACE_IDLE_STATUS, processor_status_outputs);
    wc(32'h0000_4000);
    chk("no emu", 0, ent);
    trace_exception_emulate <= 1'b1;
    t = tog;
    repeat (8) @(posedge clk);
    chk("trace resumed", 1, tog != t);
    chk("status on", 32'h0000_0005, processor_status_outputs);
    chk("trace emu", 1, ent);
    {trace_exception_emulate, force_emulator_entry, code} <= 3'b011;
    wc(32'h0000_8000);
    chk("special on", 1, spc);
    chk("tt", dcf_pkg::TT_EMU, tt);
    chk("tm code", dcf_pkg::TM_EMU_CODE, tm);
    code <= 1'b0;
    @(posedge clk);
    chk("tm data", dcf_pkg::TM_EMU_DATA, tm);
    wc(32'h0);
    chk("special off", 0, spc);
    op(1'b1, 2'h1, 0);
    pin();
    chk("halt", 1, halt);
    irqs(0);
    wc(32'h0004_0000);
    pin();
    irqs(1);
    pin();
    irqs(0);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    wc(32'h0000_1000);
    op(1'b0, 2'h1, 2);
    op(1'b0, 2'h0, 8);
    op(1'b1, 2'h1, 0);
    wc(32'h0000_1800);
    op(1'b1, 2'h2, 4);
    wc(32'h0000_0800);
    op(1'b0, 2'h1, 0);
    bus(1'b1, 1'b1, dcf_pkg::HOSTCTRL_OFFSET, 32'h0001_0000);
    chk("inhibit", 1, inh);
    wc(32'h0000_2000);
    bus(1'b1, 1'b0, dcf_pkg::HOSTCTRL_OFFSET, 32'h0000_0000);
    bus(1'b0, 1'b0, dcf_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl locked", 32'h0001_0000, q);
    bus(1'b0, 1'b0, 4'hC, 32'h0);
    chk("unmapped", 0, q);
    results();
  end
endmodule : debug_control_field_logic_tb_top
`default_nettype wire
